// [rtl/dpbr_pkg.sv]
// Package with constants and carrier types of the dual-port block RAM.
package dpbr_pkg;

	// ==========================================================
	// Storage geometry
	localparam int BLOCK_BITS  = 9216;
	localparam int HALF_BITS   = 9;
	localparam int WORD_BITS   = 2 * HALF_BITS;
	localparam int BLOCK_DEPTH = BLOCK_BITS / WORD_BITS;
	localparam int WORD_AW     = $clog2(BLOCK_DEPTH);
	localparam int ADDR_W      = WORD_AW + 2;
	localparam int DATA_W      = 2 * WORD_BITS;
	localparam int HALF_EN_W   = DATA_W / HALF_BITS;
	localparam int SYNC_STAGES = 2;

	// ==========================================================
	// Configuration choices
	typedef enum logic [1:0] {
		DPBR_SINGLE,
		DPBR_VERTICAL,
		DPBR_HORIZONTAL
	} dpbr_cascade_type;

	typedef enum logic [1:0] {
		DPBR_X9,
		DPBR_X18,
		DPBR_X36
	} dpbr_width_type;

	// ==========================================================
	// Port carriers
	typedef struct packed {
		logic                 chipSel;
		logic                 wrEn;
		logic [HALF_EN_W-1:0] halfEn;
		logic [ADDR_W-1:0]    addr;
		logic [DATA_W-1:0]    data;
	} dpbr_wr_type;

	typedef struct packed {
		logic              chipSel;
		logic [ADDR_W-1:0] addr;
	} dpbr_rd_type;

	typedef struct packed {
		logic               blk;
		logic [WORD_AW-1:0] word;
		logic               half;
	} dpbr_loc_type;

endpackage : dpbr_pkg

// [rtl/dpbr_pin_sync.sv]
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module dpbr_pin_sync
	import dpbr_pkg::*;
#(
	parameter int WIDTH = 1
) (
	// Clock, reset and enable
	input  wire logic             core_clk,
	input  wire logic             srst,
	input  wire logic             ce,
	// Pins and synchronised copy
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1_r;

	// ==========================================================
	// Synchroniser stages
	always_ff @(posedge core_clk) begin
		if (srst) begin
			stage1_r <= '0;
			syncOut  <= '0;
		end else if (ce) begin
			stage1_r <= pinIn;
			syncOut  <= stage1_r;
		end
	end

endmodule : dpbr_pin_sync

// [rtl/dpbr_ram_block.sv]
// One storage block with two half-word write enables and a read port.
`timescale 1ns/1ps
module dpbr_ram_block
	import dpbr_pkg::*;
#(
	parameter int DEPTH  = BLOCK_DEPTH,
	parameter int HALF_W = HALF_BITS
) (
	// Clock, reset and enable
	input  wire logic                     core_clk,
	input  wire logic                     srst,
	input  wire logic                     ce,
	// Write side
	input  wire logic [1:0]               wrHalfEn,
	input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
	input  wire logic [2*HALF_W-1:0]      wrData,
	// Read side
	input  wire logic                     rdEn,
	input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
	output logic      [2*HALF_W-1:0]      rdData
);

	logic [2*HALF_W-1:0] mem [DEPTH];

	// ==========================================================
	// Storage writes, one enable for each half.
	always_ff @(posedge core_clk) begin
		if (ce) begin
			for (int h = 0; h < 2; h++) begin
				if (wrHalfEn[h]) begin
					mem[wrAddr][h*HALF_W +: HALF_W] <= wrData[h*HALF_W +: HALF_W]; // [RULE7]
				end
			end
		end
	end

	// ==========================================================
	// Storage reads.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			rdData <= '0;
		end else if (ce && rdEn) begin
			rdData <= mem[rdAddr]; // [RULE1]
		end
	end

endmodule : dpbr_ram_block

// [rtl/dpbr_ram_top.sv]
// Dual-port block RAM pair with sampled port clocks and cascade modes.
//
// How it works
// [RULE1] Each block holds 9,216 bits with separate write and read ports.
// [RULE2] Write and read ports each follow their own, unrelated clock.
// [RULE3] Each port clock can be taken true or inverted.
// [RULE4] Read and write widths are chosen independently of each other.
// [RULE5] Depth and width set the address bits and which bits are selected.
// [RULE6] One block alone is 512 words of 18 bits.
// [RULE7] Two write enables each gate one 9-bit half of a word.
// [RULE8] An optional output register adds one read clock of latency.
// [RULE9] Two blocks stack into 1024 by 18; the top address bit picks one.
// [RULE10] Two blocks side by side form 512 by 36, sharing addresses.
// [RULE11] Either two-block cascade needs no extra user logic.
// [RULE12] Chip selects must be active for a port to act; the optional output register still loads and flags valid on every read edge.
`timescale 1ns/1ps
module dpbr_ram_top
	import dpbr_pkg::*;
(
	// Core clock, reset and enable
	input  wire logic             core_clk,
	input  wire logic             srst,
	input  wire logic             ce,
	// Configuration
	input  wire dpbr_cascade_type cascadeMode,
	input  wire dpbr_width_type   wrWidth,
	input  wire dpbr_width_type   rdWidth,
	input  wire logic             wrClkInvert,
	input  wire logic             rdClkInvert,
	input  wire logic             rdPipeEn,
	// Write port pins
	input  wire logic             wrClk,
	input  wire dpbr_wr_type      wrPort,
	// Read port pins
	input  wire logic             rdClk,
	input  wire dpbr_rd_type      rdPort,
	// Read results
	output logic [DATA_W-1:0]     rdData,
	output logic                  rdValid
);

	localparam int WR_SYNC_W = 1 + $bits(dpbr_wr_type);
	localparam int RD_SYNC_W = 1 + $bits(dpbr_rd_type);

	// ==========================================================
	// Pin synchronisers
	logic [WR_SYNC_W-1:0] wrSync;
	logic [RD_SYNC_W-1:0] rdSync;
	dpbr_wr_type          wrReq;
	dpbr_rd_type          rdReq;
	logic                 wrClkLevel;
	logic                 rdClkLevel;

	dpbr_pin_sync #(
		.WIDTH(WR_SYNC_W)
	) wrSyncInst (
		.core_clk(core_clk),
		.srst    (srst),
		.ce      (ce),
		.pinIn   ({wrClk, wrPort}),
		.syncOut (wrSync)
	);

	dpbr_pin_sync #(
		.WIDTH(RD_SYNC_W)
	) rdSyncInst (
		.core_clk(core_clk),
		.srst    (srst),
		.ce      (ce),
		.pinIn   ({rdClk, rdPort}),
		.syncOut (rdSync)
	);

	assign wrReq      = dpbr_wr_type'(wrSync[WR_SYNC_W-2:0]);
	assign rdReq      = dpbr_rd_type'(rdSync[RD_SYNC_W-2:0]);
	assign wrClkLevel = wrSync[WR_SYNC_W-1] ^ wrClkInvert; // [RULE3]
	assign rdClkLevel = rdSync[RD_SYNC_W-1] ^ rdClkInvert; // [RULE3]

	// ==========================================================
	// Port clock edge detection
	logic wrLevelPrev_r;
	logic rdLevelPrev_r;
	logic wrEdge;
	logic rdEdge;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			// Start high so the settling synchronisers give no false edge.
			wrLevelPrev_r <= 1'b1;
			rdLevelPrev_r <= 1'b1;
		end else if (ce) begin
			wrLevelPrev_r <= wrClkLevel;
			rdLevelPrev_r <= rdClkLevel;
		end
	end

	assign wrEdge = wrClkLevel & ~wrLevelPrev_r; // [RULE2]
	assign rdEdge = rdClkLevel & ~rdLevelPrev_r; // [RULE2]

	// ==========================================================
	// Address mapping
	function automatic dpbr_width_type effWidth(
		input dpbr_width_type   w,
		input dpbr_cascade_type m
	);
		if (w == DPBR_X36 && m != DPBR_HORIZONTAL) begin
			return DPBR_X18;
		end
		return w;
	endfunction : effWidth

	function automatic dpbr_loc_type decode(
		input logic [ADDR_W-1:0] a,
		input dpbr_width_type    w,
		input dpbr_cascade_type  m
	);
		dpbr_loc_type loc;
		loc = '0;
		unique case (w)
			DPBR_X36: begin
				loc.word = a[WORD_AW-1:0]; // [RULE10]
			end
			DPBR_X18: begin
				unique case (m)
					DPBR_SINGLE: begin
						loc.word = a[WORD_AW-1:0]; // [RULE6]
					end
					DPBR_VERTICAL: begin
						loc.blk  = a[WORD_AW]; // [RULE9]
						loc.word = a[WORD_AW-1:0];
					end
					DPBR_HORIZONTAL: begin
						loc.blk  = a[0];
						loc.word = a[WORD_AW:1];
					end
					default: begin
						loc.word = a[WORD_AW-1:0];
					end
				endcase
			end
			DPBR_X9: begin
				loc.half = a[0]; // [RULE5]
				unique case (m)
					DPBR_SINGLE: begin
						loc.word = a[WORD_AW:1];
					end
					DPBR_VERTICAL: begin
						loc.blk  = a[WORD_AW+1]; // [RULE9]
						loc.word = a[WORD_AW:1];
					end
					DPBR_HORIZONTAL: begin
						loc.blk  = a[1];
						loc.word = a[WORD_AW+1:2];
					end
					default: begin
						loc.word = a[WORD_AW:1];
					end
				endcase
			end
			default: begin
				loc.word = a[WORD_AW-1:0];
			end
		endcase
		return loc;
	endfunction : decode

	dpbr_width_type wrW;
	dpbr_width_type rdW;
	dpbr_loc_type   wrLoc;
	dpbr_loc_type   rdLoc;

	assign wrW   = effWidth(wrWidth, cascadeMode); // [RULE4]
	assign rdW   = effWidth(rdWidth, cascadeMode); // [RULE4]
	assign wrLoc = decode(wrReq.addr, wrW, cascadeMode); // [RULE5]
	assign rdLoc = decode(rdReq.addr, rdW, cascadeMode); // [RULE5]

	// ==========================================================
	// Write steering to the two blocks
	logic                 wrGo;
	logic [1:0]           blkHalfEn [2];
	logic [WORD_BITS-1:0] blkWrData [2];

	assign wrGo = wrEdge & wrReq.chipSel & wrReq.wrEn; // [RULE12]

	always_comb begin
		for (int b = 0; b < 2; b++) begin
			blkHalfEn[b] = 2'b00;
			blkWrData[b] = wrReq.data[WORD_BITS-1:0];
			unique case (wrW)
				DPBR_X36: begin
					blkHalfEn[b] = wrReq.halfEn[2*b +: 2]; // [RULE10]
					blkWrData[b] = wrReq.data[b*WORD_BITS +: WORD_BITS];
				end
				DPBR_X18: begin
					if (wrLoc.blk == b[0]) begin
						blkHalfEn[b] = wrReq.halfEn[1:0]; // [RULE7]
					end
				end
				DPBR_X9: begin
					blkWrData[b] = {2{wrReq.data[HALF_BITS-1:0]}};
					if (wrLoc.blk == b[0] && wrReq.halfEn[0]) begin
						blkHalfEn[b] = wrLoc.half ? 2'b10 : 2'b01; // [RULE5]
					end
				end
				default: begin
					blkHalfEn[b] = 2'b00;
				end
			endcase
			if (!wrGo) begin
				blkHalfEn[b] = 2'b00; // [RULE12]
			end
		end
	end

	// ==========================================================
	// Storage blocks, both addressed alike on reads
	logic                 rdGo;
	logic [WORD_BITS-1:0] blkQ [2];

	assign rdGo = rdEdge & rdReq.chipSel; // [RULE12]

	for (genvar b = 0; b < 2; b++) begin : gBlk
		dpbr_ram_block #(
			.DEPTH (BLOCK_DEPTH),
			.HALF_W(HALF_BITS)
		) blockInst (
			.core_clk(core_clk),
			.srst    (srst),
			.ce      (ce),
			.wrHalfEn(blkHalfEn[b]),
			.wrAddr  (wrLoc.word),
			.wrData  (blkWrData[b]),
			.rdEn    (rdGo),
			.rdAddr  (rdLoc.word),
			.rdData  (blkQ[b])
		); // [RULE11]
	end

	// ==========================================================
	// Read selection state
	dpbr_loc_type   rdSel_r;
	dpbr_width_type rdSelW_r;
	logic           rdBusy_r;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			rdSel_r  <= '0;
			rdSelW_r <= DPBR_X18;
			rdBusy_r <= 1'b0;
		end else if (ce) begin
			rdBusy_r <= rdGo;
			if (rdGo) begin
				rdSel_r  <= rdLoc;
				rdSelW_r <= rdW;
			end
		end
	end

	// ==========================================================
	// Read data shaping
	logic [DATA_W-1:0]    rdShaped;
	logic [WORD_BITS-1:0] rdWord;

	always_comb begin
		rdWord   = rdSel_r.blk ? blkQ[1] : blkQ[0]; // [RULE9]
		rdShaped = '0;
		unique case (rdSelW_r)
			DPBR_X36: begin
				rdShaped = {blkQ[1], blkQ[0]}; // [RULE10]
			end
			DPBR_X18: begin
				rdShaped[WORD_BITS-1:0] = rdWord;
			end
			DPBR_X9: begin
				rdShaped[HALF_BITS-1:0] = rdSel_r.half ?
					rdWord[WORD_BITS-1:HALF_BITS] :
					rdWord[HALF_BITS-1:0]; // [RULE5]
			end
			default: begin
				rdShaped = '0;
			end
		endcase
	end

	// ==========================================================
	// Direct and pipelined output stages
	logic [DATA_W-1:0] rdFlow_r;
	logic [DATA_W-1:0] rdPipe_r;
	logic              flowValid_r;
	logic              pipeValid_r;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			rdFlow_r    <= '0;
			flowValid_r <= 1'b0;
		end else if (ce) begin
			flowValid_r <= rdBusy_r;
			if (rdBusy_r) begin
				rdFlow_r <= rdShaped;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			rdPipe_r    <= '0;
			pipeValid_r <= 1'b0;
		end else if (ce) begin
			pipeValid_r <= 1'b0;
			if (rdEdge) begin
				rdPipe_r    <= rdFlow_r; // [RULE8]
				pipeValid_r <= 1'b1;
			end
		end
	end

	assign rdData  = rdPipeEn ? rdPipe_r : rdFlow_r; // [RULE8]
	assign rdValid = rdPipeEn ? pipeValid_r : flowValid_r;

endmodule : dpbr_ram_top

// [bench/dpbr_ram_sva.sv]
// Assertion checker for the dual-port block RAM top.
`timescale 1ns/1ps
module dpbr_ram_sva
	import dpbr_pkg::*;
(
	// Clock, reset and enable
	input wire logic              core_clk,
	input wire logic              srst,
	input wire logic              ce,
	// Read configuration and pins
	input wire dpbr_cascade_type  cascadeMode,
	input wire dpbr_width_type    rdWidth,
	input wire logic              rdClkInvert,
	input wire logic              rdPipeEn,
	input wire logic              rdClk,
	input wire dpbr_rd_type       rdPort,
	// Read results
	input wire logic [DATA_W-1:0] rdData,
	input wire logic              rdValid
);
	// =====
	// Active read edge and cycles since it.
	logic       act;
	logic       actLast_r;
	logic [3:0] age_r;
	assign act = rdClk ^ rdClkInvert;
	always_ff @(posedge core_clk) begin
		actLast_r <= act;
	end
	always_ff @(posedge core_clk) begin
		if (srst)
			age_r <= 4'hf;
		else if (act && !actLast_r)
			age_r <= 4'h0;
		else if (age_r != 4'hf)
			age_r <= age_r + 4'h1;
	end
	// =====
	// Assertions.
	a_reset_clears: assert property (@(posedge core_clk)
		srst && ce |=> rdData == '0 && !rdValid)
		else $error("read output not cleared by reset");
	a_direct_latency: assert property (@(posedge core_clk)
		disable iff (srst || !ce)
		$rose(act) && rdPort.chipSel && !rdPipeEn |-> ##[2:5] rdValid)
		else $error("direct read gave no result");
	a_pipe_latency: assert property (@(posedge core_clk)
		disable iff (srst || !ce)
		$rose(act) && rdPort.chipSel && rdPipeEn |-> ##[1:5] rdValid)
		else $error("pipelined read gave no result");
	a_read_needs_cs: assert property (@(posedge core_clk)
		disable iff (srst || !ce)
		$rose(act) && !rdPort.chipSel && !rdPipeEn |=> !rdValid [*6])
		else $error("read without chip select");
	a_valid_pulse: assert property (@(posedge core_clk)
		disable iff (srst || !ce) rdValid |=> !rdValid)
		else $error("valid longer than one cycle");
	a_data_with_valid: assert property (@(posedge core_clk)
		disable iff (srst || !ce) !rdValid |-> $stable(rdData))
		else $error("read data moved without valid");
	a_valid_has_edge: assert property (@(posedge core_clk)
		disable iff (srst || !ce)
		rdValid |-> age_r >= 4'h1 && age_r <= 4'h6)
		else $error("valid without a read edge");
	a_x9_upper_zero: assert property (@(posedge core_clk)
		disable iff (srst || !ce) rdValid && rdWidth == DPBR_X9
		|-> rdData[DATA_W-1:HALF_BITS] == '0)
		else $error("narrow read not zero extended");
	a_x18_upper_zero: assert property (@(posedge core_clk)
		disable iff (srst || !ce) rdValid && !(rdWidth == DPBR_X36
		&& cascadeMode == DPBR_HORIZONTAL)
		|-> rdData[DATA_W-1:WORD_BITS] == '0)
		else $error("upper half set outside wide mode");
endmodule : dpbr_ram_sva

bind dpbr_ram_top dpbr_ram_sva dpbr_ram_sva_inst (
	.core_clk(core_clk), .srst(srst), .ce(ce),
	.cascadeMode(cascadeMode), .rdWidth(rdWidth),
	.rdClkInvert(rdClkInvert), .rdPipeEn(rdPipeEn), .rdClk(rdClk),
	.rdPort(rdPort), .rdData(rdData), .rdValid(rdValid));

// [bench/dpbr_fabric_user.sv]
// Behavioural fabric logic driving the write and read ports.
`timescale 1ns/1ps
module dpbr_fabric_user
	import dpbr_pkg::*;
(
	// Clock and pin clock polarity
	input  wire logic core_clk,
	input  wire logic wrInv,
	input  wire logic rdInv,
	// Port pins
	output logic        wrClk,
	output dpbr_wr_type wrPort,
	output logic        rdClk,
	output dpbr_rd_type rdPort
);
	// =====
	// Pin clocks rest at their inactive level.
	logic wrLvl = 1'b0;
	logic rdLvl = 1'b0;
	assign wrClk = wrLvl ^ wrInv;
	assign rdClk = rdLvl ^ rdInv;
	initial begin
		wrPort = '0;
		rdPort = '0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : hold
	// Pins stay put four cycles around each active edge.
	task automatic write(input logic [10:0] a, input logic [35:0] d,
		input logic [3:0] en, input logic cs);
		wrPort = '{cs, 1'b1, en, a, d};
		hold(4);
		wrLvl = 1'b1;
		hold(4);
		wrLvl = 1'b0;
		hold(2);
		wrPort = '{cs, 1'b1, en, ~a, ~d};
		hold(2);
	endtask : write
	task automatic read(input logic [10:0] a, input logic cs);
		rdPort = '{cs, a};
		hold(4);
		rdLvl = 1'b1;
		hold(4);
		rdLvl = 1'b0;
		hold(2);
		rdPort = '{cs, ~a};
		hold(2);
	endtask : read
endmodule : dpbr_fabric_user

// [bench/testbench.sv]
// Self-checking testbench of the dual-port block RAM.
`timescale 1ns/1ps
module testbench;
	import dpbr_pkg::*;
	// =====
	// Stimulus and results
	logic             core_clk;
	logic             srst;
	logic             ce;
	dpbr_cascade_type mode;
	dpbr_width_type   wrW;
	dpbr_width_type   rdW;
	logic             inv;
	logic             pipe;
	logic             wrClk;
	logic             rdClk;
	dpbr_wr_type      wrPort;
	dpbr_rd_type      rdPort;
	logic [35:0]      rdData;
	logic             rdValid;
	int               fail_count = 0;
	int               total_checks = 0;
	dpbr_ram_top dpbr_ram_top_inst (.core_clk(core_clk), .srst(srst),
		.ce(ce), .cascadeMode(mode), .wrWidth(wrW), .rdWidth(rdW),
		.wrClkInvert(inv), .rdClkInvert(inv), .rdPipeEn(pipe),
		.wrClk(wrClk), .wrPort(wrPort), .rdClk(rdClk), .rdPort(rdPort),
		.rdData(rdData), .rdValid(rdValid));
	dpbr_fabric_user dpbr_fabric_user_inst (.core_clk(core_clk),
		.wrInv(inv), .rdInv(inv), .wrClk(wrClk), .wrPort(wrPort),
		.rdClk(rdClk), .rdPort(rdPort));
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// =====
	// Shared tasks
	task automatic chk(input string nm, input logic [35:0] e, g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic cfg(input dpbr_cascade_type m,
		input dpbr_width_type w, r, input logic i, p);
		@(posedge core_clk);
		#1;
		mode = m;
		wrW = w;
		rdW = r;
		inv = i;
		pipe = p;
		srst = 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		srst = 1'b0;
	endtask : cfg
	task automatic wr(input logic [10:0] a, input logic [35:0] d,
		input logic [3:0] en, input logic cs);
		dpbr_fabric_user_inst.write(a, d, en, cs);
	endtask : wr
	task automatic rd(input logic [10:0] a, input logic cs, input int v);
		int n;
		n = 0;
		fork
			dpbr_fabric_user_inst.read(a, cs);
			repeat (12) begin
				@(posedge core_clk);
				#1;
				if (rdValid === 1'b1)
					n++;
			end
		join
		chk("valid count", 36'(v), 36'(n));
	endtask : rd
	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run
	// =====
	// Scenarios
	task automatic t_single;
		cfg(DPBR_SINGLE, DPBR_X18, DPBR_X18, 1'b0, 1'b0);
		wr(11'h005, 36'h2a5a5, 4'h3, 1'b1);
		rd(11'h005, 1'b1, 1);
		chk("word", 36'h2a5a5, rdData);
		wr(11'h005, 36'h3ffff, 4'h1, 1'b1);
		wr(11'h005, 36'h00000, 4'h3, 1'b0);
		rd(11'h205, 1'b1, 1);
		chk("half", 36'h2a5ff, rdData);
		rd(11'h000, 1'b0, 0);
		chk("held", 36'h2a5ff, rdData);
		ce = 1'b0;
		wr(11'h005, 36'h00000, 4'h3, 1'b1);
		ce = 1'b1;
		rd(11'h005, 1'b1, 1);
		chk("frozen", 36'h2a5ff, rdData);
	endtask : t_single
	task automatic t_vertical;
		cfg(DPBR_VERTICAL, DPBR_X18, DPBR_X18, 1'b0, 1'b0);
		wr(11'h005, 36'h11111, 4'h3, 1'b1);
		wr(11'h205, 36'h22222, 4'h3, 1'b1);
		rd(11'h005, 1'b1, 1);
		chk("low blk", 36'h11111, rdData);
		rd(11'h205, 1'b1, 1);
		chk("high blk", 36'h22222, rdData);
	endtask : t_vertical
	task automatic t_horizontal;
		cfg(DPBR_HORIZONTAL, DPBR_X18, DPBR_X36, 1'b0, 1'b0);
		wr(11'h00e, 36'h16789, 4'h3, 1'b1);
		wr(11'h00f, 36'h048d1, 4'h3, 1'b1);
		rd(11'h007, 1'b1, 1);
		chk("wide", 36'h123456789, rdData);
	endtask : t_horizontal
	task automatic t_narrow_pipe;
		cfg(DPBR_SINGLE, DPBR_X9, DPBR_X18, 1'b1, 1'b1);
		wr(11'h00b, 36'h001c3, 4'h1, 1'b1);
		rd(11'h005, 1'b1, 1);
		chk("pipe first", 36'h0, rdData);
		rd(11'h000, 1'b1, 1);
		chk("pipe", 36'h38711, rdData);
		cfg(DPBR_SINGLE, DPBR_X9, DPBR_X9, 1'b1, 1'b0);
		rd(11'h00b, 1'b1, 1);
		chk("x9", 36'h001c3, rdData);
	endtask : t_narrow_pipe
	// =====
	// Main sequence
	initial begin
		srst = 1'b1;
		ce = 1'b1;
		mode = DPBR_SINGLE;
		wrW = DPBR_X18;
		rdW = DPBR_X18;
		inv = 1'b0;
		pipe = 1'b0;
		repeat (6) @(posedge core_clk);
		#1;
		srst = 1'b0;
		chk("reset", 36'h0, rdData);
		t_single();
		t_vertical();
		t_horizontal();
		t_narrow_pipe();
		complete_run();
	end
endmodule : testbench
